// ===== inc/dlsfb_cfg.svh
// Register map, field positions, reset values and timing counts
`ifndef DLSFB_CFG_SVH
`define DLSFB_CFG_SVH
// Device register indices; byte address is four times the index
`define DLSFB_CKSEL_IDX    16'hff56
`define DLSFB_CTRL_IDX     16'hff57
`define DLSFB_STAT_IDX     16'hff58
`define DLSFB_RXD_IDX      16'hff59
`define DLSFB_CKSEL_RST    8'h00
`define DLSFB_CODE_MAX     4'ha
// Control and status fields
`define DLSFB_CTRL_PWR_BIT 0
`define DLSFB_STAT_DONE    0
`define DLSFB_STAT_ERR     1
`define DLSFB_STAT_BUSY    2
// Receiver timing: base clock tick counts within a bit, then bit indices within the frame
`define DLSFB_TICKS_BIT    4'hf
`define DLSFB_SMP_FIRST    4'h4
`define DLSFB_SMP_SECOND   4'hc
`define DLSFB_LAST_BIT     5'h12
`define DLSFB_STOP_FIRST   5'h11
// Host register byte addresses and reset values
`define DLSFB_H_TX_ADDR    18'h00000
`define DLSFB_H_STAT_ADDR  18'h00004
`define DLSFB_H_HALF_ADDR  18'h00008
`define DLSFB_H_HALF_RST   16'h0008
`define DLSFB_H_HALVES     6'h26
// Bus responses
`define DLSFB_RESP_OK      2'h0
`define DLSFB_RESP_ERR     2'h2
`endif

// ===== inc/dlsfb_pkg.sv
// Shared types of the lighting link frame logic
package dlsfb_pkg;
  typedef logic [17:0] dlsfb_addr_t;
  typedef logic [31:0] dlsfb_word_t;
  typedef logic [1:0]  dlsfb_resp_t;
  typedef enum logic {DLSFB_IDLE, DLSFB_BUSY} dlsfb_state_e;
endpackage

// ===== inc/dlsfb_if.sv
// Single-wire lighting link with open-drain drivers at both ends
`timescale 1ns/10ps
interface dlsfb_if;
  logic m_o;
  logic m_oe;
  logic s_o;
  logic s_oe;
  logic line;
  // Pulled high; any enabled driver showing low pulls it down
  assign line = !((m_oe && !m_o) || (s_oe && !s_o));
  modport master (output m_o, output m_oe, input line);
  modport slave  (output s_o, output s_oe, input line);
endinterface

// ===== verilog/dlsfb_slave.sv
// Slave end: base clock select, forward frame receiver, AXI4-Lite registers
`timescale 1ns/10ps
`include "dlsfb_cfg.svh"

// Notes on behaviour
// [R1] Base clock is peripheral clock over two-power code
// [R2] Software never writes codes above ten
// [R3] Software changes code only while unit off
// [R4] Clock select: 8 bits, upper four zero
// [R5] Unit acts only as link slave
// [R6] Mid-bit fall is zero, rise is one
// [R7] Line rests high when idle
// [R8] Forward frame spans nineteen bit periods
// [R9] Start bit looks like a one
// [R10] Address byte then data byte follow start
// [R11] Stop portion stays high without transitions
// [R12] Two stop bits; bytes sent MSB first
// [R13] Sample at half-bit centres; flag missing transitions
module dlsfb_slave (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write channels
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire dlsfb_pkg::dlsfb_addr_t awaddr,
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire dlsfb_pkg::dlsfb_word_t wdata,
  input  wire logic [3:0]           wstrb,
  output logic                      bvalid,
  input  wire logic                 bready,
  output dlsfb_pkg::dlsfb_resp_t    bresp,
  // AXI4-Lite read channels
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire dlsfb_pkg::dlsfb_addr_t araddr,
  output logic                      rvalid,
  input  wire logic                 rready,
  output dlsfb_pkg::dlsfb_word_t    rdata,
  output dlsfb_pkg::dlsfb_resp_t    rresp,
  // Link
  dlsfb_if.slave                    link
);
  import dlsfb_pkg::*;

  logic              aw_got;
  dlsfb_addr_t       aw_addr;
  logic              w_got;
  dlsfb_word_t       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic [3:0]        code;
  logic              power;
  logic              done_flag;
  logic              err_flag;
  logic [15:0]       rx_word;
  logic [9:0]        pre_cnt;
  logic [3:0]        code_eff;
  logic [9:0]        div_mask;
  logic              base_tick;
  dlsfb_state_e      state;
  logic              line_prev;
  logic [3:0]        tick_cnt;
  logic [4:0]        bit_idx;
  logic              first_half;
  logic [15:0]       shift;
  logic              set_done;
  logic              set_err;
  logic              clr_done;
  logic              clr_err;
  logic              frame_start;
  logic              smp_second;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Address and data may come in either order; write once both are held
  assign awready  = !aw_got;
  assign wready   = !w_got;
  assign arready  = !rvalid;
  assign do_write = aw_got && w_got && !bvalid;

  // Capture of write address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      aw_addr <= '0;
      w_got   <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_got  <= 1'b1;
        aw_addr <= awaddr;
      end else if (do_write) begin
        aw_got <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got  <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_write) begin
        w_got <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `DLSFB_RESP_OK;
    end else if (do_write) begin
      bvalid <= 1'b1;
      if (aw_addr[17:2] == `DLSFB_CKSEL_IDX || aw_addr[17:2] == `DLSFB_CTRL_IDX ||
          aw_addr[17:2] == `DLSFB_STAT_IDX || aw_addr[17:2] == `DLSFB_RXD_IDX) begin
        bresp <= `DLSFB_RESP_OK;
      end else begin
        bresp <= `DLSFB_RESP_ERR;
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Clock select and power registers, both in byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code  <= 4'(`DLSFB_CKSEL_RST);
      power <= 1'b0;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr[17:2] == `DLSFB_CKSEL_IDX) begin
        code <= w_data[3:0]; // see [R4]
      end else if (aw_addr[17:2] == `DLSFB_CTRL_IDX) begin
        power <= w_data[`DLSFB_CTRL_PWR_BIT];
      end
    end
  end

  // Write-one-to-clear of the status flags
  assign clr_done = do_write && w_strb[0] && aw_addr[17:2] == `DLSFB_STAT_IDX && w_data[`DLSFB_STAT_DONE];
  assign clr_err  = do_write && w_strb[0] && aw_addr[17:2] == `DLSFB_STAT_IDX && w_data[`DLSFB_STAT_ERR];

  // Read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `DLSFB_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= `DLSFB_RESP_OK;
      if (araddr[17:2] == `DLSFB_CKSEL_IDX) begin
        rdata <= {28'h0000000, code}; // see [R4]
      end else if (araddr[17:2] == `DLSFB_CTRL_IDX) begin
        rdata <= {31'h00000000, power};
      end else if (araddr[17:2] == `DLSFB_STAT_IDX) begin
        rdata <= {29'h00000000, state == DLSFB_BUSY, err_flag, done_flag};
      end else if (araddr[17:2] == `DLSFB_RXD_IDX) begin
        rdata <= {16'h0000, rx_word};
      end else begin
        rdata <= '0;
        rresp <= `DLSFB_RESP_ERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Base clock divider
  // ----------------------------------------------------------------
  // Prohibited codes clamp to the slowest rate rather than wrapping
  assign code_eff  = (code > `DLSFB_CODE_MAX) ? `DLSFB_CODE_MAX : code; // see [R2]
  assign div_mask  = 10'((11'h001 << code_eff) - 11'h001);
  assign base_tick = power && ((pre_cnt & div_mask) == div_mask); // see [R1]

  // Free-running prescaler, parked while the unit is off
  always_ff @(posedge aclk) begin
    if (!aresetn || !power) begin
      pre_cnt <= '0; // see [R3]
    end else begin
      pre_cnt <= pre_cnt + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Forward frame receiver
  // ----------------------------------------------------------------
  // Link never driven: replies are not built into this end
  assign link.s_o  = 1'b1;
  assign link.s_oe = 1'b0; // see [R5]

  // Falling edge from the high rest level opens the start bit
  assign frame_start = state == DLSFB_IDLE && power && line_prev && !link.line; // see [R7]
  assign smp_second  = state == DLSFB_BUSY && base_tick && tick_cnt == `DLSFB_SMP_SECOND;

  // Bit decision at the second half-bit centre
  always_comb begin
    set_done = 1'b0;
    set_err  = 1'b0;
    if (smp_second) begin
      if (bit_idx == 5'h00) begin
        set_err = !(!first_half && link.line); // see [R9]
      end else if (bit_idx < `DLSFB_STOP_FIRST) begin
        set_err = first_half == link.line; // see [R13]
      end else begin
        set_err  = !(first_half && link.line); // see [R11]
        set_done = !set_err && bit_idx == `DLSFB_LAST_BIT; // see [R8]
      end
    end
  end

  // Bit timing, sampling and shifting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= DLSFB_IDLE;
      line_prev  <= 1'b1;
      tick_cnt   <= '0;
      bit_idx    <= '0;
      first_half <= 1'b1;
      shift      <= '0;
    end else begin
      line_prev <= link.line;
      if (!power || set_err || set_done) begin
        state <= DLSFB_IDLE;
      end else if (frame_start) begin
        state    <= DLSFB_BUSY;
        tick_cnt <= '0;
        bit_idx  <= '0;
      end else if (state == DLSFB_BUSY && base_tick) begin
        tick_cnt <= tick_cnt + 4'h1;
        if (tick_cnt == `DLSFB_SMP_FIRST) begin
          first_half <= link.line; // see [R13]
        end
        if (smp_second && bit_idx != 5'h00 && bit_idx < `DLSFB_STOP_FIRST) begin
          shift <= {shift[14:0], link.line}; // see [R6], [R10], [R12]
        end
        if (tick_cnt == `DLSFB_TICKS_BIT) begin
          bit_idx <= bit_idx + 5'h01;
        end
      end
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag <= 1'b0;
      err_flag  <= 1'b0;
      rx_word   <= '0;
    end else begin
      if (set_done) begin
        done_flag <= 1'b1;
        rx_word   <= shift;
      end else if (clr_done) begin
        done_flag <= 1'b0;
      end
      if (set_err) begin
        err_flag <= 1'b1;
      end else if (clr_err) begin
        err_flag <= 1'b0;
      end
    end
  end
endmodule

// ===== verilog/dlsfb_master.sv
// Master end: forward frame transmitter ordered over AXI4-Lite
`timescale 1ns/10ps
`include "dlsfb_cfg.svh"
module dlsfb_master (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write channels
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire dlsfb_pkg::dlsfb_addr_t awaddr,
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire dlsfb_pkg::dlsfb_word_t wdata,
  input  wire logic [3:0]           wstrb,
  output logic                      bvalid,
  input  wire logic                 bready,
  output dlsfb_pkg::dlsfb_resp_t    bresp,
  // AXI4-Lite read channels
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire dlsfb_pkg::dlsfb_addr_t araddr,
  output logic                      rvalid,
  input  wire logic                 rready,
  output dlsfb_pkg::dlsfb_word_t    rdata,
  output dlsfb_pkg::dlsfb_resp_t    rresp,
  // Link
  dlsfb_if.master                   link
);
  import dlsfb_pkg::*;

  logic         aw_got;
  dlsfb_addr_t  aw_addr;
  logic         w_got;
  dlsfb_word_t  w_data;
  logic [3:0]   w_strb;
  logic         do_write;
  logic         start;
  logic [15:0]  tx_word;
  logic [15:0]  half_len;
  logic [15:0]  half_cnt;
  logic [5:0]   halves_left;
  logic [37:0]  pattern;
  logic [31:0]  data_halves;
  dlsfb_state_e state;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign awready  = !aw_got;
  assign wready   = !w_got;
  assign arready  = !rvalid;
  assign do_write = aw_got && w_got && !bvalid;
  // Frame order refused while a frame is on the wire
  assign start    = do_write && aw_addr == `DLSFB_H_TX_ADDR && state == DLSFB_IDLE;

  // Capture of write address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      aw_addr <= '0;
      w_got   <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_got  <= 1'b1;
        aw_addr <= awaddr;
      end else if (do_write) begin
        aw_got <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got  <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_write) begin
        w_got <= 1'b0;
      end
    end
  end

  // Write response and register updates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid   <= 1'b0;
      bresp    <= `DLSFB_RESP_OK;
      tx_word  <= '0;
      half_len <= `DLSFB_H_HALF_RST;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= `DLSFB_RESP_OK;
      if (start) begin
        tx_word <= w_data[15:0];
      end else if (aw_addr == `DLSFB_H_HALF_ADDR && w_strb[1:0] == 2'h3) begin
        // Zero would stall the timer, so it becomes one
        half_len <= (w_data[15:0] == 16'h0000) ? 16'h0001 : w_data[15:0];
      end else begin
        bresp <= `DLSFB_RESP_ERR;
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `DLSFB_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= `DLSFB_RESP_OK;
      if (araddr == `DLSFB_H_TX_ADDR) begin
        rdata <= {16'h0000, tx_word};
      end else if (araddr == `DLSFB_H_STAT_ADDR) begin
        rdata <= {31'h00000000, state == DLSFB_BUSY};
      end else if (araddr == `DLSFB_H_HALF_ADDR) begin
        rdata <= {16'h0000, half_len};
      end else begin
        rdata <= '0;
        rresp <= `DLSFB_RESP_ERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Frame shaping
  // ----------------------------------------------------------------
  // Each payload bit becomes its inverse then itself, MSB first
  for (genvar i = 0; i < 16; i++) begin : g_half
    assign data_halves[2*i+1] = !w_data[i]; // see [R6], [R12]
    assign data_halves[2*i]   = w_data[i];
  end

  // Open drain: only low halves enable the driver
  assign link.m_o  = 1'b0;
  assign link.m_oe = state == DLSFB_BUSY && !pattern[37];

  // Half-bit sequencer over 38 halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= DLSFB_IDLE;
      pattern     <= '1;
      half_cnt    <= '0;
      halves_left <= '0;
    end else if (start) begin
      state       <= DLSFB_BUSY;
      pattern     <= {2'b01, data_halves, 4'hf}; // see [R9], [R10], [R11]
      half_cnt    <= 16'h0001;
      halves_left <= `DLSFB_H_HALVES; // see [R8]
    end else if (state == DLSFB_BUSY) begin
      if (half_cnt == half_len) begin
        half_cnt    <= 16'h0001;
        pattern     <= {pattern[36:0], 1'b1};
        halves_left <= halves_left - 6'h01;
        if (halves_left == 6'h01) begin
          state <= DLSFB_IDLE; // see [R7]
        end
      end else begin
        half_cnt <= half_cnt + 16'h0001;
      end
    end
  end
endmodule

// ===== verif/dlsfb_chk.sv
// Wire-level checks on the lighting link joining both ends
`timescale 1ns/10ps
module dlsfb_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link signals
  input wire logic m_o,
  input wire logic m_oe,
  input wire logic s_o,
  input wire logic s_oe,
  input wire logic line
);
  // ------------------------------
  // Helper logic
  // ------------------------------
  logic [9:0] low_cnt;

  // Length of the present low run; saturates so it never wraps
  always_ff @(posedge aclk) begin
    if (!aresetn || line) begin
      low_cnt <= 10'h000;
    end else if (low_cnt != 10'h3ff) begin
      low_cnt <= low_cnt + 10'h001;
    end
  end

  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_slave_stays_quiet:
    assert property (!s_oe) else $error("slave drove the link");
  a_release_gives_high:
    assert property (!m_oe && !s_oe |-> line) else $error("released line not high");
  a_pull_low_only:
    assert property (m_oe |-> !m_o) else $error("master drives a high level");
  a_fall_has_cause:
    assert property ($fell(line) |-> m_oe) else $error("line fell without a driver");
  a_low_half_min:
    assert property ($fell(line) |-> !line [*8]) else $error("low half too short");
  a_high_half_min:
    assert property ($rose(line) |-> line [*8]) else $error("high half too short");
  a_low_run_max:
    assert property (low_cnt <= 10'h020) else $error("low run over two halves");
  a_idle_after_reset:
    assert property ($rose(aresetn) |-> line) else $error("line not idle after reset");

  // Main scenarios seen on the wire
  c_frame_start: cover property ($fell(line));
  c_two_short_halves: cover property (low_cnt == 10'h010);
  c_two_long_halves: cover property (low_cnt == 10'h020);
endmodule

// ===== verif/test_dali_slave_frame_and_baud_clock.sv
// Self-checking bench for both link ends, their registers and the wire
`timescale 1ns/10ps
`include "dlsfb_cfg.svh"
module test_dali_slave_frame_and_baud_clock;
  import dlsfb_pkg::*;
  // ------------------------------
  // Signals
  // ------------------------------
  localparam dlsfb_addr_t CK = {`DLSFB_CKSEL_IDX, 2'b00};
  localparam dlsfb_addr_t CT = {`DLSFB_CTRL_IDX, 2'b00};
  localparam dlsfb_addr_t ST = {`DLSFB_STAT_IDX, 2'b00};
  localparam dlsfb_addr_t RX = {`DLSFB_RXD_IDX, 2'b00};
  logic             aclk         = 1'b0;
  logic             aresetn      = 1'b0;
  logic [1:0]       awvalid      = 2'b00;
  logic [1:0]       wvalid       = 2'b00;
  logic [1:0]       arvalid      = 2'b00;
  logic [1:0]       bready       = 2'b00;
  logic [1:0]       rready       = 2'b00;
  dlsfb_addr_t      awaddr [2]   = '{default: '0};
  dlsfb_addr_t      araddr [2]   = '{default: '0};
  dlsfb_word_t      wdata [2]    = '{default: '0};
  logic [3:0]       wstrb [2]    = '{default: 4'hf};
  wire [1:0]        awready;
  wire [1:0]        wready;
  wire [1:0]        bvalid;
  wire [1:0]        arready;
  wire [1:0]        rvalid;
  wire dlsfb_resp_t bresp [2];
  wire dlsfb_resp_t rresp [2];
  wire dlsfb_word_t rdata [2];
  int               fail_count   = 0;
  int               total_checks = 0;
  int               cyc          = 0;
  int               half         = 8;
  logic [15:0]      exp_q [$];

  dlsfb_if lnk ();

  dlsfb_slave dlsfb_slave_inst (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid[0]), .awready(awready[0]), .awaddr(awaddr[0]),
    .wvalid(wvalid[0]), .wready(wready[0]), .wdata(wdata[0]), .wstrb(wstrb[0]),
    .bvalid(bvalid[0]), .bready(bready[0]), .bresp(bresp[0]),
    .arvalid(arvalid[0]), .arready(arready[0]), .araddr(araddr[0]),
    .rvalid(rvalid[0]), .rready(rready[0]), .rdata(rdata[0]), .rresp(rresp[0]),
    .link(lnk.slave)
  );

  dlsfb_master dlsfb_master_inst (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid[1]), .awready(awready[1]), .awaddr(awaddr[1]),
    .wvalid(wvalid[1]), .wready(wready[1]), .wdata(wdata[1]), .wstrb(wstrb[1]),
    .bvalid(bvalid[1]), .bready(bready[1]), .bresp(bresp[1]),
    .arvalid(arvalid[1]), .arready(arready[1]), .araddr(araddr[1]),
    .rvalid(rvalid[1]), .rready(rready[1]), .rdata(rdata[1]), .rresp(rresp[1]),
    .link(lnk.master)
  );

  dlsfb_chk dlsfb_chk_inst (
    .aclk(aclk), .aresetn(aresetn), .m_o(lnk.m_o), .m_oe(lnk.m_oe),
    .s_o(lnk.s_o), .s_oe(lnk.s_oe), .line(lnk.line)
  );

  // Clock: 25 MHz
  always #20 aclk = ~aclk;

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [37:0] e, input logic [37:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready is sampled at the negedge before the taking edge, where it is settled
  task automatic wr(input int e, input dlsfb_addr_t a, input dlsfb_word_t d, output dlsfb_resp_t r);
    logic ta;
    logic tw;
    logic tb;
    tb = 1'b0;
    @(posedge aclk);
    awvalid[e] <= 1'b1;
    awaddr[e]  <= a;
    wvalid[e]  <= 1'b1;
    wdata[e]   <= d;
    bready[e]  <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = awready[e];
      tw = wready[e];
      tb = bvalid[e];
      r  = bresp[e];
      @(posedge aclk);
      if (ta) awvalid[e] <= 1'b0;
      if (tw) wvalid[e] <= 1'b0;
      if (tb) bready[e] <= 1'b0;
    end
  endtask

  task automatic rd(input int e, input dlsfb_addr_t a, output dlsfb_word_t d, output dlsfb_resp_t r);
    logic ta;
    logic tb;
    tb = 1'b0;
    @(posedge aclk);
    arvalid[e] <= 1'b1;
    araddr[e]  <= a;
    rready[e]  <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = arready[e];
      tb = rvalid[e];
      d  = rdata[e];
      r  = rresp[e];
      @(posedge aclk);
      if (ta) arvalid[e] <= 1'b0;
      if (tb) rready[e] <= 1'b0;
    end
  endtask

  task automatic wchk(input int e, input dlsfb_addr_t a, input dlsfb_word_t d, input dlsfb_resp_t x);
    dlsfb_resp_t r;
    wr(e, a, d, r);
    chk("bresp", x, r);
  endtask

  task automatic rchk(input int e, input dlsfb_addr_t a, input dlsfb_word_t x, input string nm);
    dlsfb_word_t d;
    dlsfb_resp_t r;
    rd(e, a, d, r);
    chk(nm, x, d);
    chk("rresp", `DLSFB_RESP_OK, r);
  endtask

  // Start a frame, check a second start is refused, wait till idle
  task automatic send(input logic [15:0] w, input logic bsy);
    dlsfb_word_t d;
    dlsfb_resp_t r;
    wchk(1, `DLSFB_H_TX_ADDR, {16'h0000, w}, `DLSFB_RESP_OK);
    exp_q.push_back(w);
    wchk(1, `DLSFB_H_TX_ADDR, 32'h0, `DLSFB_RESP_ERR);
    // A powered receiver is inside the start bit by now
    rd(0, ST, d, r);
    chk("receiving", bsy, d[2]);
    d = 32'h1;
    while (d[0] !== 1'b0) rd(1, `DLSFB_H_STAT_ADDR, d, r);
    // The refused start must not have replaced the word
    rchk(1, `DLSFB_H_TX_ADDR, {16'h0000, w}, "tx word");
  endtask

  // Model of the wire: start, Manchester bits MSB first, two high stop bits
  function automatic logic [37:0] frame_bits(input logic [15:0] w);
    logic [37:0] f;
    f = 38'h1;
    for (int b = 15; b >= 0; b--) f = {f[35:0], ~w[b], w[b]};
    return {f[33:0], 4'hf};
  endfunction

  // Decode each frame at half-bit centres and compare with the model
  always begin
    logic [37:0] g;
    @(negedge lnk.line);
    repeat (half / 2) @(negedge aclk);
    for (int i = 37; i >= 0; i--) begin
      g[i] = lnk.line;
      if (i > 0) repeat (half) @(negedge aclk);
    end
    chk("wire frame", frame_bits(exp_q.pop_front()), g);
  end

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    dlsfb_word_t d;
    dlsfb_resp_t r;
    logic [15:0] w;
    void'($urandom(25));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(0, CK, 32'h0, "clock select");
    rchk(1, `DLSFB_H_HALF_ADDR, 32'h8, "half length");
    rchk(0, ST, 32'h0, "status");
    wchk(0, CK, 32'hfa, `DLSFB_RESP_OK);
    rchk(0, CK, 32'ha, "clock select");
    rd(0, 18'h00100, d, r);
    chk("unmapped data", 32'h0, d);
    chk("unmapped resp", `DLSFB_RESP_ERR, r);
    wchk(0, 18'h00100, 32'h0, `DLSFB_RESP_ERR);
    wchk(0, CK, 32'h0, `DLSFB_RESP_OK);
    send(16'h1234, 1'b0);
    rchk(0, ST, 32'h0, "unit off");
    wchk(0, CT, 32'h1, `DLSFB_RESP_OK);
    for (int n = 0; n < 4; n++) begin
      w = 16'($urandom);
      send(w, 1'b1);
      rchk(0, ST, 32'h1, "done");
      rchk(0, RX, {16'h0000, w}, "rx word");
      wchk(0, ST, 32'h3, `DLSFB_RESP_OK);
      rchk(0, ST, 32'h0, "cleared");
    end
    // Half length needs both low byte lanes; a partial write is refused
    wstrb[1] <= 4'h1;
    wchk(1, `DLSFB_H_HALF_ADDR, 32'h10, `DLSFB_RESP_ERR);
    wstrb[1] <= 4'hf;
    rchk(1, `DLSFB_H_HALF_ADDR, 32'h8, "half kept");
    // Halves twice as long as code 0 expects
    half = 16;
    wchk(1, `DLSFB_H_HALF_ADDR, 32'h10, `DLSFB_RESP_OK);
    send(16'h5a5a, 1'b1);
    rchk(0, ST, 32'h2, "framing error");
    rchk(0, RX, {16'h0000, w}, "rx kept");
    wchk(0, CT, 32'h0, `DLSFB_RESP_OK);
    wchk(0, CK, 32'h1, `DLSFB_RESP_OK);
    wchk(0, ST, 32'h3, `DLSFB_RESP_OK);
    wchk(0, CT, 32'h1, `DLSFB_RESP_OK);
    send(16'h5a5a, 1'b1);
    rchk(0, ST, 32'h1, "done code 1");
    rchk(0, RX, 32'h5a5a, "rx word");
    wrap_up();
  end
endmodule
